// >>> src/ssim_pkg.sv
// Package of constants and types for the serial shift-in engine.
package ssim_pkg;

  // **********************************************************************
  // Register map
  // **********************************************************************
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  CTRL_OFS   = 8'h00;
  localparam logic [7:0]  FIELDS_OFS = 8'h04;
  localparam logic [7:0]  TIMING_OFS = 8'h08;
  localparam logic [7:0]  STATUS_OFS = 8'h0C;
  localparam logic [7:0]  RXDATA_OFS = 8'h10;

  // **********************************************************************
  // Field positions
  // **********************************************************************
  localparam int unsigned CTRL_MODE_LSB   = 0;
  localparam int unsigned CTRL_NF_LSB     = 4;
  localparam int unsigned CTRL_START_BIT  = 8;
  localparam int unsigned FIELD_STRIDE    = 8;
  localparam int unsigned TIMING_HI_LSB   = 0;
  localparam int unsigned TIMING_LO_LSB   = 16;
  localparam int unsigned STAT_BUSY_BIT   = 0;
  localparam int unsigned STAT_DONE_BIT   = 1;
  localparam int unsigned STAT_NEMPTY_BIT = 2;
  localparam int unsigned STAT_FULL_BIT   = 3;
  localparam int unsigned STAT_LEVEL_LSB  = 8;
  localparam int unsigned RX_VALID_BIT    = 31;
  localparam int unsigned RX_LAST_BIT     = 30;
  localparam int unsigned RX_IDX_LSB      = 16;
  localparam int unsigned MODE_LSB_FIRST  = 0;
  localparam int unsigned MODE_POST       = 1;
  localparam int unsigned MODE_IDLE_HIGH  = 2;

  // **********************************************************************
  // Sizes and reset values
  // **********************************************************************
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned MAX_FIELDS   = 4;
  localparam int unsigned FIFO_DEPTH   = 32;
  localparam logic [4:0]  DEFAULT_BITS = 5'h08;
  localparam logic [4:0]  MAX_BITS     = 5'h10;
  localparam logic [2:0]  CTRL_MODE_RST = 3'h0;
  localparam logic [1:0]  CTRL_NF_RST   = 2'h0;
  localparam logic [4:0]  FIELD_RST     = 5'h00;
  localparam logic [15:0] PHASE_RST     = 16'h000A;

  typedef enum logic [2:0] {
    msb_first_sample_before    = 3'h0,
    lsb_first_sample_before    = 3'h1,
    msb_first_sample_after     = 3'h2,
    lsb_first_sample_after     = 3'h3,
    msb_first_before_idle_high = 3'h4,
    lsb_first_before_idle_high = 3'h5,
    msb_first_after_idle_high  = 3'h6,
    lsb_first_after_idle_high  = 3'h7
  } ssim_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LEAD, ST_SAMPLE, ST_ACTIVE, ST_REST, ST_PUSH
  } ssim_state_t;

  typedef struct packed {
    logic        last;
    logic [1:0]  idx;
    logic [15:0] data;
  } ssim_word_t;

  typedef struct packed {
    logic [2:0]       mode;
    logic [1:0]       nf;
    logic [3:0][4:0]  fcnt;
    logic [15:0]      hi_cyc;
    logic [15:0]      lo_cyc;
    logic             done_flag;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             sync1;
    logic             sync2;
    logic             oe;
    logic             sdo;
    logic             sclk;
    logic             busy;
    logic             done;
    ssim_state_t      state;
    logic [2:0]       run_mode;
    logic [1:0]       run_nf;
    logic [1:0]       fld;
    logic [4:0]       total;
    logic [4:0]       left;
    logic [15:0]      phase;
    logic [15:0]      shreg;
  } ssim_top_state_t;

endpackage

// >>> src/ssim_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
module ssim_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [AW:0]           level
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } ssim_fifo_state_t;

  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  ssim_fifo_state_t q;
  ssim_fifo_state_t d;
  logic             push;
  logic             pop;

  assign in_ready  = (q.cnt != FULL_CNT);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign level     = q.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == LAST_IDX) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == LAST_IDX) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // ssim_fifo

// >>> src/ssim_top.sv
// Serial shift-in master engine with APB registers and result FIFO.
//
// Contract
// - Modes 0 and 4: MSB first, sample before each clock pulse.
// - Modes 1 and 5: LSB first, sample before each clock pulse.
// - Modes 2 and 6: MSB first, sample after each clock pulse.
// - Modes 3 and 7: LSB first, sample after each clock pulse.
// - Modes 0-3 clock rests low; modes 4-7 clock rests high.
// - On start, clock goes to idle level and data pin becomes input.
// - Data pin stays an input after the transfer ends.
// - MSB-first enters at low end shifting left; LSB-first at high end right.
// - Each bit gets one clock pulse away from idle and back.
// - Sample, pulse, shift repeat until the field's bit count is collected.
// - Bit count per field is 1 to 16, defaulting to 8.
// - Several fields per operation, each own count, bits back to back.
// - Single field returns its value directly as the result word.
module ssim_top
  import ssim_pkg::*;
#(
  parameter int unsigned FDEPTH = FIFO_DEPTH
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  output logic                    sclk,
  input  wire logic               sdio_i,
  output logic                    sdio_o,
  output logic                    sdio_oe,
  output logic                    busy,
  output logic                    done
);

  localparam int unsigned WW = $bits(ssim_word_t);
  localparam int unsigned LW = $clog2(FDEPTH) + 1;

  ssim_top_state_t q;
  ssim_top_state_t d;

  // **********************************************************************
  // Result FIFO
  // **********************************************************************
  logic       f_in_valid;
  logic       f_in_ready;
  ssim_word_t f_in_data;
  logic       f_out_valid;
  logic       f_out_ready;
  ssim_word_t f_out_data;
  logic [LW-1:0] f_level;

  ssim_fifo #(
    .WIDTH (WW),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data),
    .level     (f_level)
  );

  // **********************************************************************
  // Helpers
  // **********************************************************************
  function automatic logic [4:0] bits_of(input logic [4:0] c);
    if (c == 5'h00) begin
      return DEFAULT_BITS;
    end else if (c > MAX_BITS) begin
      return MAX_BITS;
    end
    return c;
  endfunction

  // A zero count would end the phase at once like one does, so it means one cycle
  function automatic logic [15:0] cyc_of(input logic [15:0] c);
    return (c == 16'h0000) ? 16'h0001 : c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // **********************************************************************
  // Register views
  // **********************************************************************
  logic [31:0] ctrl_rd;
  logic [31:0] fields_rd;
  logic [31:0] timing_rd;
  logic [31:0] status_rd;
  logic [31:0] rx_rd;
  logic [31:0] rd_val;
  logic        mapped;
  logic        setup;
  logic        access;

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[CTRL_MODE_LSB +: 3] = q.mode;
    ctrl_rd[CTRL_NF_LSB +: 2]   = q.nf;
    fields_rd = '0;
    for (int i = 0; i < MAX_FIELDS; i++) begin
      fields_rd[i*FIELD_STRIDE +: 5] = q.fcnt[i];
    end
    timing_rd = '0;
    timing_rd[TIMING_HI_LSB +: 16] = q.hi_cyc;
    timing_rd[TIMING_LO_LSB +: 16] = q.lo_cyc;
    status_rd = '0;
    status_rd[STAT_BUSY_BIT]   = q.busy;
    status_rd[STAT_DONE_BIT]   = q.done_flag;
    status_rd[STAT_NEMPTY_BIT] = f_out_valid;
    status_rd[STAT_FULL_BIT]   = ~f_in_ready;
    status_rd[STAT_LEVEL_LSB +: LW] = f_level;
    rx_rd = '0;
    rx_rd[RX_VALID_BIT]      = f_out_valid;
    rx_rd[RX_LAST_BIT]       = f_out_data.last;
    rx_rd[RX_IDX_LSB +: 2]   = f_out_data.idx;
    rx_rd[DATA_W-1:0]        = f_out_data.data;
    mapped = 1'b1;
    unique case (paddr)
      CTRL_OFS:   rd_val = ctrl_rd;
      FIELDS_OFS: rd_val = fields_rd;
      TIMING_OFS: rd_val = timing_rd;
      STATUS_OFS: rd_val = status_rd;
      RXDATA_OFS: rd_val = rx_rd;
      default: begin
        rd_val = '0;
        mapped = 1'b0;
      end
    endcase
  end

  assign setup  = psel & ~penable;
  assign access = psel & penable & q.pready;

  // Pop only a word that the captured read actually showed
  assign f_out_ready = access & ~pwrite & (paddr == RXDATA_OFS) &
                       q.prdata[RX_VALID_BIT] & ~q.pslverr;
  assign f_in_valid  = (q.state == ST_PUSH);

  always_comb begin
    f_in_data = '0;
    f_in_data.last = (q.fld == q.run_nf);
    f_in_data.idx  = q.fld;
    if (q.run_mode[MODE_LSB_FIRST]) begin
      f_in_data.data = q.shreg >> (5'h10 - q.total);
    end else begin
      f_in_data.data = q.shreg;
    end
  end

  // **********************************************************************
  // Next state
  // **********************************************************************
  logic [31:0] wval;
  logic        start;
  logic        done_ev;
  logic        idle_lvl;
  logic        post;

  always_comb begin
    d = q;
    wval    = '0;
    start   = 1'b0;
    done_ev = 1'b0;
    idle_lvl = q.run_mode[MODE_IDLE_HIGH];
    post     = q.run_mode[MODE_POST];

    // Pin synchroniser
    d.sync1 = sdio_i;
    d.sync2 = q.sync1;

    // Bus answer is prepared in the setup cycle
    d.pready  = setup;
    d.pslverr = setup & ~mapped;
    d.prdata  = (setup && !pwrite) ? rd_val : '0;
    d.done    = 1'b0;

    if (access && pwrite) begin
      unique case (paddr)
        CTRL_OFS: begin
          wval   = merge(ctrl_rd, pwdata, pstrb);
          d.mode = wval[CTRL_MODE_LSB +: 3];
          d.nf   = wval[CTRL_NF_LSB +: 2];
          start  = wval[CTRL_START_BIT] & pstrb[1];
        end
        FIELDS_OFS: begin
          wval = merge(fields_rd, pwdata, pstrb);
          for (int i = 0; i < MAX_FIELDS; i++) begin
            d.fcnt[i] = wval[i*FIELD_STRIDE +: 5];
          end
        end
        TIMING_OFS: begin
          wval     = merge(timing_rd, pwdata, pstrb);
          d.hi_cyc = wval[TIMING_HI_LSB +: 16];
          d.lo_cyc = wval[TIMING_LO_LSB +: 16];
        end
        STATUS_OFS: begin
          if (pstrb[0] && pwdata[STAT_DONE_BIT]) begin
            d.done_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    unique case (q.state)
      ST_IDLE: begin
        if (start) begin
          d.run_mode = d.mode;
          d.run_nf   = d.nf;
          d.fld      = 2'h0;
          d.total    = bits_of(d.fcnt[0]);
          d.left     = bits_of(d.fcnt[0]);
          d.shreg    = '0;
          d.sclk     = d.mode[MODE_IDLE_HIGH];
          d.oe       = 1'b0;
          d.phase    = cyc_of(d.lo_cyc);
          d.busy     = 1'b1;
          d.state    = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (q.phase <= 16'h0001) begin
          if (post) begin
            d.sclk  = ~idle_lvl;
            d.phase = cyc_of(q.hi_cyc);
            d.state = ST_ACTIVE;
          end else begin
            d.state = ST_SAMPLE;
          end
        end else begin
          d.phase = q.phase - 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (q.run_mode[MODE_LSB_FIRST]) begin
          d.shreg = {q.sync2, q.shreg[15:1]};
        end else begin
          d.shreg = {q.shreg[14:0], q.sync2};
        end
        d.left = q.left - 1'b1;
        if (post && q.left == 5'h01) begin
          d.state = ST_PUSH;
        end else begin
          d.sclk  = ~idle_lvl;
          d.phase = cyc_of(q.hi_cyc);
          d.state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (q.phase <= 16'h0001) begin
          d.sclk  = idle_lvl;
          d.phase = cyc_of(q.lo_cyc);
          d.state = ST_REST;
        end else begin
          d.phase = q.phase - 1'b1;
        end
      end
      ST_REST: begin
        if (q.phase <= 16'h0001) begin
          if (post) begin
            d.state = ST_SAMPLE;
          end else if (q.left == 5'h00) begin
            d.state = ST_PUSH;
          end else begin
            d.state = ST_SAMPLE;
          end
        end else begin
          d.phase = q.phase - 1'b1;
        end
      end
      ST_PUSH: begin
        // Clock rests at idle while the FIFO is full
        if (f_in_ready) begin
          if (q.fld == q.run_nf) begin
            d.busy  = 1'b0;
            done_ev = 1'b1;
            d.state = ST_IDLE;
          end else begin
            d.fld   = q.fld + 1'b1;
            d.total = bits_of(q.fcnt[q.fld + 1'b1]);
            d.left  = bits_of(q.fcnt[q.fld + 1'b1]);
            d.shreg = '0;
            if (post) begin
              d.sclk  = ~idle_lvl;
              d.phase = cyc_of(q.hi_cyc);
              d.state = ST_ACTIVE;
            end else begin
              d.state = ST_SAMPLE;
            end
          end
        end
      end
    endcase

    d.done = done_ev;
    // Hardware set wins over a software clear
    if (done_ev) begin
      d.done_flag = 1'b1;
    end
  end

  // **********************************************************************
  // State register
  // **********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.mode      <= CTRL_MODE_RST;
      q.nf        <= CTRL_NF_RST;
      q.fcnt      <= {MAX_FIELDS{FIELD_RST}};
      q.hi_cyc    <= PHASE_RST;
      q.lo_cyc    <= PHASE_RST;
      q.oe        <= 1'b1;
      q.state     <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // **********************************************************************
  // Outputs
  // **********************************************************************
  assign pready  = q.pready;
  assign prdata  = q.prdata;
  assign pslverr = q.pslverr;
  assign sclk    = q.sclk;
  assign sdio_o  = q.sdo;
  assign sdio_oe = q.oe;
  assign busy    = q.busy;
  assign done    = q.done;

endmodule // ssim_top

// >>> tb/ssim_asserts.sv
// Concurrent checks on the ports of the serial shift-in engine.
module ssim_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sclk,
  input wire logic        sdio_oe,
  input wire logic        busy,
  input wire logic        done
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // **********************************************************************
  // Link side
  // **********************************************************************
  a_oe_stays_input: assert property (!sdio_oe |=> !sdio_oe)
    else $error("data pin returned to output");
  a_busy_pin_input: assert property (busy |-> !sdio_oe)
    else $error("data pin driven during transfer");
  a_done_one_cycle: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_done_ends_busy: assert property (done |-> !busy && $past(busy))
    else $error("done without preceding busy");
  a_busy_until_done: assert property ($fell(busy) |-> done)
    else $error("busy dropped without done");
  a_idle_clock_still: assert property (!busy && !$past(busy) |-> $stable(sclk))
    else $error("shift clock moved while idle");

  // **********************************************************************
  // Register bus
  // **********************************************************************
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held past access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");

  c_done: cover property (done);
  c_pin_input: cover property ($fell(sdio_oe));
  c_error: cover property (pslverr);
endmodule // ssim_asserts

bind ssim_top ssim_asserts ssim_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .sclk(sclk), .sdio_oe(sdio_oe), .busy(busy),
  .done(done)
);

// >>> tb/ssim_periph.sv
// Behavioural serial peripheral shifting a fixed pattern to the engine.
module ssim_periph (
  input  wire logic        pclk,
  input  wire logic        cs_n,
  input  wire logic        idle_hi,
  input  wire logic [63:0] pattern,
  input  wire logic        sclk,
  output logic             sdio
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] n_q;
  logic       sclk_q;
  logic       tog_q;

  // Plain always, so the toggle may start from a known level
  initial tog_q = 1'b0;

  always @(posedge pclk) begin
    sclk_q <= sclk;
    tog_q  <= ~tog_q;
    if (cs_n) begin
      n_q <= 6'h00;
    end else if (sclk != sclk_q && sclk != idle_hi) begin
      n_q <= n_q + 6'h01;
    end
  end
  // Deselected line toggles, so a stale bit cannot pass for data
  assign sdio = cs_n ? tog_q : pattern[n_q];
endmodule // ssim_periph

// >>> tb/ssim_tb.sv
// Self-checking bench for the serial shift-in engine.
module ssim_tb
  import ssim_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CNT [4] = '{5, 1, 0, 16};
  logic        pclk, presetn, psel, penable, pwrite, sdio_i, cs_n, idle_hi;
  logic        pready, pslverr, sclk, sdio_o, sdio_oe, busy, done;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, r;
  logic [63:0] pat;
  int          miscompares, compares;

  ssim_top #(.FDEPTH(4)) ssim_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sclk(sclk), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .busy(busy), .done(done));
  ssim_periph ssim_periph_inst (.pclk(pclk), .cs_n(cs_n), .idle_hi(idle_hi),
    .pattern(pat), .sclk(sclk), .sdio(sdio_i));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // **********************************************************************
  // Access tasks
  // **********************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Holds the request until ready is seen; trailing edge keeps drivers apart
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk({31'h0, pready}, 32'h1);
    r = prdata;
    chk({31'h0, pslverr}, {31'h0, a > RXDATA_OFS});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, done}, 32'h1);
  endtask

  // **********************************************************************
  // Expected values
  // **********************************************************************
  function automatic int nbits(input logic [2:0] m, input int f);
    int c;
    c = CNT[(f + m + m / 4) % 4];
    return (c == 0) ? 8 : c;
  endfunction

  function automatic logic [31:0] fexp(input logic [2:0] m, input int f);
    int          off;
    int          nb;
    logic [15:0] v;
    off = 0;
    v = 16'h0000;
    for (int g = 0; g < f; g++) off += nbits(m, g);
    nb = nbits(m, f);
    // Post modes see the bit shown after the pulse
    for (int k = 0; k < nb; k++) begin
      if (m[0]) v[k] = pat[off + k + m[1]];
      else v[nb - 1 - k] = pat[off + k + m[1]];
    end
    return {1'b1, f == m % 4, 12'h000, 2'(f), v};
  endfunction

  task automatic run_op(input logic [2:0] m);
    logic [31:0] fv;
    logic [31:0] cv;
    fv = 32'h0;
    for (int f = 0; f < 4; f++) fv[8*f +: 5] = 5'(CNT[(f + m + m / 4) % 4]);
    cv = {23'h0, 1'b1, 2'b00, m[1:0], 1'b0, m};
    cs_n <= 1'b1;
    idle_hi <= m[2];
    pat <= {32'hC3A5_69F0, 32'h5A3C_0F96} ^ {8{5'h00, m}};
    @(posedge pclk);
    cs_n <= 1'b0;
    xfer(1'b1, TIMING_OFS, 32'h0004_0004);
    xfer(1'b1, FIELDS_OFS, fv);
    xfer(1'b1, CTRL_OFS, cv);
    chk({28'h0, busy, sdio_oe, sdio_o, sclk}, {28'h0, 3'b100, m[2]});
    xfer(1'b1, CTRL_OFS, cv);
  endtask

  task automatic pop_words(input logic [2:0] m);
    for (int f = 0; f <= m % 4; f++) begin
      xfer(1'b0, RXDATA_OFS, 32'h0);
      chk(r, fexp(m, f));
    end
  endtask

  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #400us;
    miscompares++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    final_report;
  end

  // **********************************************************************
  // Main sequence
  // **********************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    paddr = 8'h00;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    cs_n = 1'b1;
    idle_hi = 1'b0;
    pat = 64'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({31'h0, sdio_oe}, 32'h1);
    xfer(1'b0, FIELDS_OFS, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, TIMING_OFS, 32'h0);
    chk(r, {PHASE_RST, PHASE_RST});
    xfer(1'b0, STATUS_OFS, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 8; i++) begin
      run_op(3'(i));
      wait_done;
      chk({31'h0, sclk}, {31'h0, i >= 4});
      xfer(1'b0, STATUS_OFS, 32'h0);
      chk(r, ((i % 4 + 1) << 8) | (i % 4 == 3 ? 32'h8 : 32'h0) | 32'h6);
      pop_words(3'(i));
      xfer(1'b0, RXDATA_OFS, 32'h0);
      chk({31'h0, r[31]}, 32'h0);
      xfer(1'b1, STATUS_OFS, 32'h2);
      xfer(1'b0, STATUS_OFS, 32'h0);
      chk({r[31:1], sdio_oe}, 32'h0);
    end
    // Full FIFO must hold the next operation at its first push
    run_op(3'h7);
    wait_done;
    run_op(3'h7);
    repeat (400) @(posedge pclk);
    xfer(1'b0, STATUS_OFS, 32'h0);
    chk(r, 32'h0000_040F);
    pop_words(3'h7);
    wait_done;
    pop_words(3'h7);
    final_report;
  end
endmodule // ssim_tb
